// ===== logic/external_bus_control.sv
// external parallel bus control: selects, strobes, wait states, hold
//
// Overview of operation
// - space selects idle high, low only during a valid-address access
// - space selects float while the bus is released in hold
// - memory strobe low only for data or program accesses
// - io strobe low only for io device accesses
// - direction line high, low only while writing
// - ready sampled only with two or more software wait states
// - ready not sampled until software wait states finish
// - while ready low, wait a cycle and sample again
// - after acknowledge all bus lines float until request withdrawn
// - output disable low floats selects, strobes and direction
// - acknowledge asserted while held with lines floated
// - wait-done low at first wait state, high at last, only with two or more wait states
// - address bus floats in hold or when output disable low
`timescale 1ns/1ps
`default_nettype none
`include "ext_bus_defines.svh"
module external_bus_control
    import ext_bus_pkg::*;
#(
    parameter int ADDR_WIDTH = `EXT_BUS_ADDR_WIDTH,
    parameter int DATA_WIDTH = `EXT_BUS_DATA_WIDTH,
    parameter int WAIT_WIDTH = `EXT_BUS_WAIT_WIDTH
)
(
    // clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  reset_n,
    // access requests from the cpu
    input  wire logic                  req_valid,
    input  wire space_type             req_space,
    input  wire logic                  req_write,
    input  wire logic [ADDR_WIDTH-1:0] req_addr,
    input  wire logic [DATA_WIDTH-1:0] req_wdata,
    input  wire logic [WAIT_WIDTH-1:0] req_waits,
    output logic                       req_ready,
    output logic                       done,
    output logic [DATA_WIDTH-1:0]      rdata,
    // external pins
    input  wire logic                  ready_pin,
    input  wire logic                  hold_req_n,
    input  wire logic                  out_disable_n,
    output logic                       data_space_select,
    output logic                       program_space_select,
    output logic                       io_space_select,
    output logic                       mem_strobe_n,
    output logic                       io_device_strobe_n,
    output logic                       rw,
    output logic                       ctrl_oe,
    output logic [ADDR_WIDTH-1:0]      addr,
    output logic                       addr_oe,
    input  wire logic [DATA_WIDTH-1:0] data_in,
    output logic [DATA_WIDTH-1:0]      data_out,
    output logic                       data_oe,
    output logic                       bus_release_ack_n,
    output logic                       wait_sequence_done,
    output logic                       status_oe
);
    // ------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------
    // the wait counter has to reach the two-state ready threshold
    if (WAIT_WIDTH < 2)
    begin : g_wait_width_check
        $error("wait count must reach two");
    end
    // a zero-width bus leaves nothing to drive
    if (ADDR_WIDTH < 1 || DATA_WIDTH < 1)
    begin : g_bus_width_check
        $error("bus widths must be positive");
    end

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic [DATA_WIDTH-1:0] din_a;
    logic [DATA_WIDTH-1:0] din_b;
    logic ready_s;
    logic hold_s;
    logic off_s;

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            sync_a <= 3'h7;
            sync_b <= 3'h7;
            din_a  <= '0;
            din_b  <= '0;
        end
        else
        begin
            sync_a <= {ready_pin, hold_req_n, out_disable_n};
            sync_b <= sync_a;
            din_a  <= data_in;
            din_b  <= din_a;
        end
    end

    assign ready_s = sync_b[2];
    assign hold_s  = !sync_b[1];
    assign off_s   = !sync_b[0];

    // ------------------------------------------------------------
    // access sequencer
    // ------------------------------------------------------------
    bus_state_type         state;
    bus_state_type         next_state;
    logic [WAIT_WIDTH-1:0] wait_cnt;
    logic [WAIT_WIDTH-1:0] next_wait_cnt;
    logic [WAIT_WIDTH-1:0] waits;
    logic [WAIT_WIDTH-1:0] next_waits;
    space_type             space;
    space_type             next_space;
    logic                  write;
    logic                  next_write;
    logic [ADDR_WIDTH-1:0] next_addr;
    logic [DATA_WIDTH-1:0] next_data_out;
    logic [DATA_WIDTH-1:0] next_rdata;
    logic                  next_done;
    logic                  finish;
    logic                  next_finish;
    logic                  next_msc;
    logic                  active;

    always_comb
    begin
        next_state    = state;
        next_wait_cnt = wait_cnt;
        next_waits    = waits;
        next_space    = space;
        next_write    = write;
        next_addr     = addr;
        next_data_out = data_out;
        // the data pins arrive two edges late through their synchroniser,
        // so done trails the pins by one edge and rdata follows done
        next_rdata    = done ? din_b : rdata;
        next_done     = finish;
        next_finish   = 1'b0;
        next_msc      = wait_sequence_done;
        unique case (state)
            st_idle:
            begin
                // req_ready is a promise: a request met with it is taken
                if (req_valid && req_ready)
                begin
                    next_state    = st_access;
                    next_space    = req_space;
                    next_write    = req_write;
                    next_addr     = req_addr;
                    next_data_out = req_wdata;
                    next_waits    = req_waits;
                    next_wait_cnt = '0;
                end
                else if (hold_s)
                    next_state = st_hold;
            end
            st_access:
            begin
                if (waits == '0)
                begin
                    next_state  = st_idle;
                    next_finish = 1'b1;
                end
                else
                begin
                    next_state = st_wait;
                    // active low at start of first wait state
                    if (waits >= `EXT_BUS_READY_MIN_WAIT)
                        next_msc = 1'b0;
                end
            end
            st_wait:
            begin
                next_wait_cnt = wait_cnt + 1'b1;
                if (wait_cnt + 1'b1 == waits - 1'b1)
                    next_msc = 1'b1;
                if (wait_cnt + 1'b1 == waits)
                begin
                    // fewer than two waits: ready is ignored
                    if (waits >= `EXT_BUS_READY_MIN_WAIT)
                        next_state = st_ready;
                    else
                    begin
                        next_state  = st_idle;
                        next_finish = 1'b1;
                    end
                end
            end
            st_ready:
            begin
                // low ready costs one more cycle, then resample
                if (ready_s)
                begin
                    next_state  = st_idle;
                    next_finish = 1'b1;
                end
            end
            st_hold:
            begin
                if (!hold_s)
                    next_state = st_idle;
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            state              <= st_idle;
            wait_cnt           <= '0;
            waits              <= '0;
            space              <= space_data;
            write              <= 1'b0;
            addr               <= '0;
            data_out           <= '0;
            rdata              <= '0;
            done               <= 1'b0;
            finish             <= 1'b0;
            wait_sequence_done <= 1'b1;
        end
        else
        begin
            state              <= next_state;
            wait_cnt           <= next_wait_cnt;
            waits              <= next_waits;
            space              <= next_space;
            write              <= next_write;
            addr               <= next_addr;
            data_out           <= next_data_out;
            rdata              <= next_rdata;
            done               <= next_done;
            finish             <= next_finish;
            wait_sequence_done <= next_msc;
        end
    end

    assign active = (next_state == st_access) || (next_state == st_wait)
                 || (next_state == st_ready);

    // ------------------------------------------------------------
    // pin levels, registered
    // ------------------------------------------------------------
    pin_drive_if pins ();
    logic in_hold;
    logic next_req_ready;

    assign in_hold        = (next_state == st_hold);
    assign pins.active    = active;
    assign pins.space     = next_space;
    assign pins.write     = next_write;
    // hold or output disable floats the control lines
    assign pins.float_req = in_hold || off_s;
    assign next_req_ready = (next_state == st_idle) && !hold_s;

    pin_decode u_decode (
        .pins (pins.decoder)
    );

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            data_space_select    <= 1'b1;
            program_space_select <= 1'b1;
            io_space_select      <= 1'b1;
            mem_strobe_n         <= 1'b1;
            io_device_strobe_n   <= 1'b1;
            rw                   <= 1'b1;
            ctrl_oe              <= 1'b0;
            addr_oe              <= 1'b0;
            data_oe              <= 1'b0;
            bus_release_ack_n    <= 1'b1;
            status_oe            <= 1'b0;
            req_ready            <= 1'b0;
        end
        else
        begin
            data_space_select    <= pins.ds_n;
            program_space_select <= pins.ps_n;
            io_space_select      <= pins.is_n;
            mem_strobe_n         <= pins.mem_strobe_n_n;
            io_device_strobe_n   <= pins.io_device_strobe_n_n;
            rw                   <= pins.rw;
            ctrl_oe              <= pins.oe;
            addr_oe              <= pins.oe;
            data_oe              <= pins.oe && active && next_write;
            bus_release_ack_n    <= !in_hold;
            status_oe            <= !off_s;
            req_ready            <= next_req_ready;
        end
    end
endmodule : external_bus_control
`default_nettype wire

// ===== logic/ext_bus_defines.svh
// timing counts and widths of the external bus control block
`ifndef EXT_BUS_DEFINES_SVH
`define EXT_BUS_DEFINES_SVH
`define EXT_BUS_ADDR_WIDTH     23
`define EXT_BUS_DATA_WIDTH     16
`define EXT_BUS_WAIT_WIDTH     3
`define EXT_BUS_READY_MIN_WAIT 3'h2
`endif

// ===== logic/ext_bus_pkg.sv
// types shared by the external bus control block
package ext_bus_pkg;
    typedef enum logic [1:0] {
        space_data,
        space_program,
        space_io
    } space_type;

    typedef enum {
        st_idle,
        st_access,
        st_wait,
        st_ready,
        st_hold
    } bus_state_type;
endpackage : ext_bus_pkg

// ===== logic/pin_drive_if.sv
// interface carrying internal pin levels and their enables
`timescale 1ns/1ps
`default_nettype none
interface pin_drive_if;
    import ext_bus_pkg::*;
    logic       active;
    space_type  space;
    logic       write;
    logic       float_req;
    logic       ds_n;
    logic       ps_n;
    logic       is_n;
    logic       mem_strobe_n_n;
    logic       io_device_strobe_n_n;
    logic       rw;
    logic       oe;
    modport source (output active, output space, output write,
                    output float_req,
                    input ds_n, input ps_n, input is_n, input mem_strobe_n_n,
                    input io_device_strobe_n_n, input rw, input oe);
    modport decoder (input active, input space, input write,
                     input float_req,
                     output ds_n, output ps_n, output is_n,
                     output mem_strobe_n_n, output io_device_strobe_n_n, output rw,
                     output oe);
endinterface : pin_drive_if
`default_nettype wire

// ===== logic/pin_decode.sv
// decodes access state into select, strobe and direction levels
`timescale 1ns/1ps
`default_nettype none
module pin_decode
    import ext_bus_pkg::*;
(
    // decoded pin levels
    pin_drive_if.decoder pins
);
    always_comb
    begin
        // only one select and one strobe per access
        pins.ds_n     = !(pins.active && pins.space == space_data);
        pins.ps_n     = !(pins.active && pins.space == space_program);
        pins.is_n     = !(pins.active && pins.space == space_io);
        pins.mem_strobe_n_n  = !(pins.active && pins.space != space_io);
        pins.io_device_strobe_n_n = !(pins.active && pins.space == space_io);
        pins.rw       = !(pins.active && pins.write);
        pins.oe       = !pins.float_req;
    end
endmodule : pin_decode
`default_nettype wire

// ===== verif/ext_bus_props.sv
// assertions on the pins of the external bus control block
`timescale 1ns/1ps
`default_nettype none
module ext_bus_props #(parameter int WAIT_WIDTH = 3)
(
    // clock and reset
    input wire logic                  sys_clk,
    input wire logic                  reset_n,
    // cpu side
    input wire logic                  req_valid,
    input wire logic                  req_ready,
    input wire logic [WAIT_WIDTH-1:0] req_waits,
    input wire logic                  done,
    // external pins
    input wire logic                  hold_req_n,
    input wire logic                  out_disable_n,
    input wire logic                  data_space_select,
    input wire logic                  program_space_select,
    input wire logic                  io_space_select,
    input wire logic                  mem_strobe_n,
    input wire logic                  io_device_strobe_n,
    input wire logic                  ctrl_oe,
    input wire logic                  addr_oe,
    input wire logic                  data_oe,
    input wire logic                  status_oe,
    input wire logic                  bus_release_ack_n,
    input wire logic                  wait_sequence_done
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    logic [2:0] sel_n;
    assign sel_n = {io_space_select, program_space_select, data_space_select};
    a_one_select: assert property ($countones(~sel_n) <= 1 &&
        (mem_strobe_n || io_device_strobe_n)) else $error("two selects low");
    a_mem_strobe: assert property (!mem_strobe_n |-> sel_n[2] &&
        !(&sel_n[1:0])) else $error("memory strobe on wrong space");
    a_io_strobe: assert property (!io_device_strobe_n |->
        !io_space_select) else $error("io strobe without io select");
    a_hold_float: assert property (!bus_release_ack_n |->
        !ctrl_oe && !addr_oe && !data_oe) else $error("driving in hold");
    a_hold_ack: assert property ($fell(hold_req_n) && req_ready &&
        !req_valid |-> ##[2:5] !bus_release_ack_n) else $error("no ack");
    a_disable_float: assert property (!out_disable_n [*4] |->
        !ctrl_oe && !addr_oe && !status_oe) else $error("not floated");
    a_quick_done: assert property (req_valid && req_ready &&
        req_waits < 2 |-> ##[3:4] done) else $error("short access late");
    a_no_early_done: assert property (req_valid && req_ready &&
        req_waits == 7 |-> ##1 !done [*8]) else $error("access ended early");
    a_msc_in_access: assert property (!wait_sequence_done |->
        !(mem_strobe_n && io_device_strobe_n)) else $error("stray wait done");
    c_hold: cover property (!bus_release_ack_n);
    c_long: cover property (!wait_sequence_done);
    c_io: cover property (!io_device_strobe_n);
endmodule : ext_bus_props
bind external_bus_control ext_bus_props #(.WAIT_WIDTH(WAIT_WIDTH)) u_props
(
    .sys_clk(sys_clk), .reset_n(reset_n), .req_valid(req_valid),
    .req_ready(req_ready), .req_waits(req_waits), .done(done),
    .hold_req_n(hold_req_n), .out_disable_n(out_disable_n),
    .data_space_select(data_space_select), .ctrl_oe(ctrl_oe),
    .program_space_select(program_space_select), .addr_oe(addr_oe),
    .io_space_select(io_space_select), .mem_strobe_n(mem_strobe_n),
    .io_device_strobe_n(io_device_strobe_n), .data_oe(data_oe),
    .status_oe(status_oe), .bus_release_ack_n(bus_release_ack_n),
    .wait_sequence_done(wait_sequence_done)
);
`default_nettype wire

// ===== verif/ext_mem_model.sv
// external memory or io device answering on the parallel bus
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model #(parameter logic [15:0] READ_WORD = 16'h5a3c)
(
    // bus pins seen from outside
    input wire logic        sys_clk,
    input wire logic        access_n,
    input wire logic        rw,
    input wire logic        data_oe,
    input wire logic [15:0] data_out,
    // how long ready stays low per access
    input wire logic [7:0]  low_cycles,
    // answers
    output logic            ready_pin,
    output logic [15:0]     data_in
);
    logic [7:0]  count = 8'h00;
    logic [15:0] last = 16'h0000;
    always @(posedge sys_clk)
    begin
        count <= access_n ? 8'h00 : count + {7'h00, count != 8'hff};
        last <= data_in;
    end
    // slow device holds ready low, then lets the pull-up win
    assign ready_pin = access_n || (count >= low_cycles);
    // undriven bus toggles so a stale value never looks valid
    assign data_in = data_oe ? data_out :
                     (!access_n && rw) ? READ_WORD : ~last;
endmodule : ext_mem_model
`default_nettype wire

// ===== verif/tb.sv
// self-checking bench of the external bus control block
`timescale 1ns/1ps
`default_nettype none
module tb
    import ext_bus_pkg::*;
;
    localparam logic [15:0] READ_WORD = 16'h5a3c;
    localparam logic [15:0] WRITE_WORD = ~READ_WORD;
    logic sys_clk = 1'b0, reset_n = 1'b0, req_valid = 1'b0, req_write = 1'b0;
    logic hold_req_n = 1'b1, out_disable_n = 1'b1;
    space_type req_space = space_data;
    logic [22:0] req_addr = 23'h000000, addr;
    logic [15:0] req_wdata = 16'h0000, rdata, data_in, data_out;
    logic [2:0] req_waits = 3'h0;
    logic [7:0] low_cycles = 8'h00;
    logic req_ready, done, ready_pin, data_space_select, program_space_select;
    logic io_space_select, mem_strobe_n, io_device_strobe_n, rw, ctrl_oe;
    logic addr_oe, data_oe, bus_release_ack_n, wait_sequence_done, status_oe;
    int bad_count = 0, n_compared = 0;
    external_bus_control u_dut (.sys_clk(sys_clk), .reset_n(reset_n),
        .req_valid(req_valid), .req_space(req_space), .req_write(req_write),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_waits(req_waits),
        .req_ready(req_ready), .done(done), .rdata(rdata),
        .ready_pin(ready_pin), .hold_req_n(hold_req_n),
        .out_disable_n(out_disable_n), .data_space_select(data_space_select),
        .program_space_select(program_space_select), .rw(rw),
        .io_space_select(io_space_select), .mem_strobe_n(mem_strobe_n),
        .io_device_strobe_n(io_device_strobe_n), .ctrl_oe(ctrl_oe),
        .addr(addr), .addr_oe(addr_oe), .data_in(data_in), .data_oe(data_oe),
        .data_out(data_out), .bus_release_ack_n(bus_release_ack_n),
        .wait_sequence_done(wait_sequence_done), .status_oe(status_oe));
    ext_mem_model #(.READ_WORD(READ_WORD)) u_mem (.sys_clk(sys_clk),
        .access_n((mem_strobe_n & io_device_strobe_n) | ~ctrl_oe), .rw(rw),
        .data_oe(data_oe), .data_out(data_out), .low_cycles(low_cycles),
        .ready_pin(ready_pin), .data_in(data_in));
    always #2.5 sys_clk = ~sys_clk;
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic access(input space_type sp, input logic wr,
                          input logic [2:0] w, input logic [7:0] lows);
        int n;
        int msc_cnt;
        logic [2:0] e;
        n = 0;
        msc_cnt = 0;
        e = 3'b111;
        e[sp] = 1'b0;
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req_space <= sp;
        req_write <= wr;
        req_waits <= w;
        req_addr <= {20'h00000, w};
        req_wdata <= WRITE_WORD;
        low_cycles <= lows;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (!req_ready && n < 50);
        check(req_ready, 1'b1);
        req_valid <= 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 300)
        begin
            @(posedge sys_clk);
            #1;
            n++;
            if (!(mem_strobe_n && io_device_strobe_n))
            begin
                check({io_space_select, program_space_select,
                       data_space_select}, e);
                check(rw, !wr);
                check(mem_strobe_n, sp == space_io);
                check(addr, {20'h00000, w});
                check(data_oe, wr);
            end
            if (data_oe === 1'b1)
                check(data_out, WRITE_WORD);
            if (wait_sequence_done === 1'b0)
                msc_cnt++;
        end
        // one extra cycle samples ready once the wait states are spent
        if (w < 3'h2 || lows == 8'h00)
            check(n, w + 2 + (w >= 3'h2));
        else
            check(n > w + 3 && n <= w + lows + 5, 1'b1);
        check(msc_cnt, (w >= 3'h2) ? w - 3'h1 : 3'h0);
        @(posedge sys_clk);
        #1;
        if (!wr)
            check(rdata, READ_WORD);
        check(mem_strobe_n & io_device_strobe_n & rw, 1'b1);
    endtask : access
    task automatic hold_test();
        @(posedge sys_clk);
        hold_req_n <= 1'b0;
        repeat (6) @(posedge sys_clk);
        req_valid <= 1'b1;
        repeat (4) @(posedge sys_clk);
        #1;
        check(bus_release_ack_n, 1'b0);
        check({ctrl_oe, addr_oe, data_oe, req_ready}, 4'h0);
        check(done, 1'b0);
        @(posedge sys_clk);
        req_valid <= 1'b0;
        hold_req_n <= 1'b1;
        repeat (6) @(posedge sys_clk);
        #1;
        check({bus_release_ack_n, ctrl_oe, req_ready}, 3'h7);
    endtask : hold_test
    task automatic disable_test();
        @(posedge sys_clk);
        out_disable_n <= 1'b0;
        repeat (5) @(posedge sys_clk);
        #1;
        check({ctrl_oe, addr_oe, status_oe}, 3'h0);
        @(posedge sys_clk);
        out_disable_n <= 1'b1;
        repeat (5) @(posedge sys_clk);
        #1;
        check({ctrl_oe, status_oe}, 2'h3);
    endtask : disable_test
    task automatic report_and_stop();
        if (bad_count == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop
    // ready held low throughout: short accesses must ignore it
    initial
    begin
        repeat (20) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (5) @(posedge sys_clk);
        for (int s = 0; s < 3; s++)
            for (int k = 0; k < 4; k++)
                access(space_type'(s[1:0]), k[0], {2'b00, k[1]}, 8'hff);
        access(space_data, 1'b0, 3'h2, 8'h00);
        access(space_io, 1'b1, 3'h7, 8'h00);
        access(space_program, 1'b0, 3'h3, 8'h04);
        hold_test();
        disable_test();
        report_and_stop();
    end
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
